// >>> rtl/strap_pkg.sv
// Constants and types shared by the serial mode and low-power strap logic.
package strap_pkg;

  // ----------------------------------------------------------------
  // Synchroniser layout
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_WIDTH = 3;
  localparam int SYNC_MODE_BIT = 0;
  localparam int SYNC_SCL_BIT = 1;
  localparam int SYNC_SDA_BIT = 2;
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Strap sampling timing
  // ----------------------------------------------------------------
  // Cycles after internal reset release before the synchronised pins hold
  // real pin levels and the straps are captured.
  localparam int SETTLE_W = 2;
  localparam logic [SETTLE_W-1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [SETTLE_W-1:0] SETTLE_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_SYNC_RESET = 2'h0;
  localparam logic STRAP_RESET = 1'h0;
  localparam logic OE_N_RESET = 1'h1;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic PIN_DRIVE_LEVEL = 1'h0;
  localparam logic FLAG_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Strap sampler states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_HOLD
  } strap_state_t;

endpackage : strap_pkg

// >>> rtl/sync_if.sv
// Interface carrying raw pin levels into the synchroniser and synced levels back.
`timescale 1ns/1ns
interface sync_if #(
  parameter int WIDTH = 3
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;

  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : sync_if

// >>> rtl/pin_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs.
`timescale 1ns/1ns
module pin_sync
  import strap_pkg::*;
#(
  parameter int WIDTH = SYNC_WIDTH
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Pin levels in, synced levels out.
  sync_if.sync port
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // The first stage is read only by the second stage.
  always_comb begin
    nxt_stage1 = port.raw;
    nxt_stage2 = stage1_ff;
  end

  // Both stages clear to a constant under reset.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_ff <= WIDTH'(SYNC_RESET);
      stage2_ff <= WIDTH'(SYNC_RESET);
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign port.synced = stage2_ff;

endmodule : pin_sync

// >>> rtl/serial_mode_and_lowpower_straps.sv
// Serial port mode routing and reset-time low-power strap capture.
`timescale 1ns/1ns

// How it works
// - With the mode select high, the serial pins are routed to the EEPROM master engine.
// - With the mode select low, the serial pins are routed to the SMBus slave engine.
// - The clock pin is sampled after reset release and a low level enables U1 and U2.
// - A high clock strap stops the downstream ports initiating U1/U2 but still lets them accept it.
// - The clock strap is ignored whenever the data strap was sampled high.
// - The data pin is sampled after reset release; high disables U1 and U2, low lets the clock strap decide.
// - With an EEPROM or SMBus host present, the configured disable bit decides instead of straps.
module serial_mode_and_lowpower_straps
  import strap_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Mode select pin.
  input wire logic serial_mode_select_in,
  // Serial clock pin, open drain.
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n_out,
  // Serial data pin, open drain.
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_n_out,
  // EEPROM master engine side.
  input wire logic eeprom_clock_drive_low_in,
  input wire logic eeprom_data_drive_low_in,
  output logic eeprom_clock_out,
  output logic eeprom_data_out,
  output logic eeprom_mode_out,
  // SMBus slave engine side.
  input wire logic smbus_clock_drive_low_in,
  input wire logic smbus_data_drive_low_in,
  output logic smbus_clock_out,
  output logic smbus_data_out,
  output logic smbus_mode_out,
  // Serial clock edge pulses for the active engine.
  output logic serial_clock_rise_out,
  output logic serial_clock_fall_out,
  // Configuration from the loaded configuration register.
  input wire logic config_present_in,
  input wire logic link_low_power_disable_in,
  // Low-power policy for the downstream ports.
  output logic straps_valid_out,
  output logic low_power_accept_out,
  output logic low_power_initiate_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic [1:0] nxt_rst_sync;
  logic rst_n;

  // Assertion is immediate; release passes two flops.
  always_comb begin
    nxt_rst_sync = {rst_sync_ff[0], 1'b1};
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= RST_SYNC_RESET;
    end else begin
      rst_sync_ff <= nxt_rst_sync;
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  sync_if #(.WIDTH(SYNC_WIDTH)) pins ();

  assign pins.raw = {serial_data_pin_in, serial_clock_pin_in, serial_mode_select_in};

  pin_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .port(pins.sync)
  );

  logic mode_eeprom;
  logic scl_level;
  logic sda_level;

  assign mode_eeprom = pins.synced[SYNC_MODE_BIT];
  assign scl_level = pins.synced[SYNC_SCL_BIT];
  assign sda_level = pins.synced[SYNC_SDA_BIT];

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  strap_state_t state_ff;
  strap_state_t nxt_state;
  logic [SETTLE_W-1:0] settle_cnt_ff;
  logic [SETTLE_W-1:0] nxt_settle_cnt;
  logic strap_clock_ff;
  logic nxt_strap_clock;
  logic strap_data_ff;
  logic nxt_strap_data;
  logic strap_done;

  // Wait for the synchronisers to carry real levels, capture once, then hold.
  always_comb begin
    nxt_state = state_ff;
    nxt_settle_cnt = settle_cnt_ff;
    nxt_strap_clock = strap_clock_ff;
    nxt_strap_data = strap_data_ff;
    case (state_ff)
      ST_SETTLE: begin
        if (settle_cnt_ff == SETTLE_CYCLES) begin
          nxt_strap_clock = scl_level;
          nxt_strap_data = sda_level;
          nxt_state = ST_HOLD;
        end else begin
          nxt_settle_cnt = settle_cnt_ff + 1'b1;
        end
      end
      ST_HOLD: begin
        nxt_state = ST_HOLD;
      end
      default: begin
        nxt_state = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_SETTLE;
      settle_cnt_ff <= SETTLE_RESET;
      strap_clock_ff <= STRAP_RESET;
      strap_data_ff <= STRAP_RESET;
    end else begin
      state_ff <= nxt_state;
      settle_cnt_ff <= nxt_settle_cnt;
      strap_clock_ff <= nxt_strap_clock;
      strap_data_ff <= nxt_strap_data;
    end
  end

  assign strap_done = (state_ff == ST_HOLD);

  // ----------------------------------------------------------------
  // Low-power policy
  // ----------------------------------------------------------------
  logic valid_ff;
  logic accept_ff;
  logic initiate_ff;
  logic nxt_valid;
  logic nxt_accept;
  logic nxt_initiate;

  // Nothing is allowed until the straps are known.
  always_comb begin
    nxt_valid = strap_done;
    nxt_accept = 1'b0;
    nxt_initiate = 1'b0;
    if (strap_done) begin
      if (config_present_in) begin
        nxt_accept = !link_low_power_disable_in;
        nxt_initiate = !link_low_power_disable_in;
      end else if (strap_data_ff) begin
        nxt_accept = 1'b0;
        nxt_initiate = 1'b0;
      end else if (strap_clock_ff) begin
        nxt_accept = 1'b1;
        nxt_initiate = 1'b0;
      end else begin
        nxt_accept = 1'b1;
        nxt_initiate = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= FLAG_RESET;
      accept_ff <= FLAG_RESET;
      initiate_ff <= FLAG_RESET;
    end else begin
      valid_ff <= nxt_valid;
      accept_ff <= nxt_accept;
      initiate_ff <= nxt_initiate;
    end
  end

  // ----------------------------------------------------------------
  // Pin routing by mode
  // ----------------------------------------------------------------
  logic scl_oe_n_ff;
  logic sda_oe_n_ff;
  logic eep_scl_ff;
  logic eep_sda_ff;
  logic smb_scl_ff;
  logic smb_sda_ff;
  logic eep_mode_ff;
  logic smb_mode_ff;
  logic pin_level_ff;
  logic nxt_scl_oe_n;
  logic nxt_sda_oe_n;
  logic nxt_eep_scl;
  logic nxt_eep_sda;
  logic nxt_smb_scl;
  logic nxt_smb_sda;
  logic nxt_eep_mode;
  logic nxt_smb_mode;

  // The pins stay released until the straps are captured, so the strap
  // levels are never masked by our own drive. The idle engine sees a
  // quiet high bus.
  always_comb begin
    nxt_scl_oe_n = OE_N_RESET;
    nxt_sda_oe_n = OE_N_RESET;
    nxt_eep_scl = LINE_IDLE;
    nxt_eep_sda = LINE_IDLE;
    nxt_smb_scl = LINE_IDLE;
    nxt_smb_sda = LINE_IDLE;
    nxt_eep_mode = 1'b0;
    nxt_smb_mode = 1'b0;
    if (strap_done) begin
      if (mode_eeprom) begin
        nxt_eep_mode = 1'b1;
        nxt_scl_oe_n = !eeprom_clock_drive_low_in;
        nxt_sda_oe_n = !eeprom_data_drive_low_in;
        nxt_eep_scl = scl_level;
        nxt_eep_sda = sda_level;
      end else begin
        nxt_smb_mode = 1'b1;
        nxt_scl_oe_n = !smbus_clock_drive_low_in;
        nxt_sda_oe_n = !smbus_data_drive_low_in;
        nxt_smb_scl = scl_level;
        nxt_smb_sda = sda_level;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_n_ff <= OE_N_RESET;
      sda_oe_n_ff <= OE_N_RESET;
      eep_scl_ff <= LINE_IDLE;
      eep_sda_ff <= LINE_IDLE;
      smb_scl_ff <= LINE_IDLE;
      smb_sda_ff <= LINE_IDLE;
      eep_mode_ff <= FLAG_RESET;
      smb_mode_ff <= FLAG_RESET;
      pin_level_ff <= PIN_DRIVE_LEVEL;
    end else begin
      scl_oe_n_ff <= nxt_scl_oe_n;
      sda_oe_n_ff <= nxt_sda_oe_n;
      eep_scl_ff <= nxt_eep_scl;
      eep_sda_ff <= nxt_eep_sda;
      smb_scl_ff <= nxt_smb_scl;
      smb_sda_ff <= nxt_smb_sda;
      eep_mode_ff <= nxt_eep_mode;
      smb_mode_ff <= nxt_smb_mode;
      pin_level_ff <= PIN_DRIVE_LEVEL; // Open drain only ever pulls low.
    end
  end

  // ----------------------------------------------------------------
  // Serial clock edge detection
  // ----------------------------------------------------------------
  logic scl_prev_ff;
  logic rise_ff;
  logic fall_ff;
  logic nxt_scl_prev;
  logic nxt_rise;
  logic nxt_fall;

  // Edges are found on the synchronised level, only once routing is live.
  always_comb begin
    nxt_scl_prev = scl_level;
    nxt_rise = strap_done && scl_level && !scl_prev_ff;
    nxt_fall = strap_done && !scl_level && scl_prev_ff;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_ff <= FLAG_RESET;
      rise_ff <= FLAG_RESET;
      fall_ff <= FLAG_RESET;
    end else begin
      scl_prev_ff <= nxt_scl_prev;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_clock_pin_out = pin_level_ff;
  assign serial_clock_pin_oe_n_out = scl_oe_n_ff;
  assign serial_data_pin_out = pin_level_ff;
  assign serial_data_pin_oe_n_out = sda_oe_n_ff;
  assign eeprom_clock_out = eep_scl_ff;
  assign eeprom_data_out = eep_sda_ff;
  assign eeprom_mode_out = eep_mode_ff;
  assign smbus_clock_out = smb_scl_ff;
  assign smbus_data_out = smb_sda_ff;
  assign smbus_mode_out = smb_mode_ff;
  assign serial_clock_rise_out = rise_ff;
  assign serial_clock_fall_out = fall_ff;
  assign straps_valid_out = valid_ff;
  assign low_power_accept_out = accept_ff;
  assign low_power_initiate_out = initiate_ff;

endmodule : serial_mode_and_lowpower_straps

// >>> verification/strap_far_side.sv
// Far-side model: strap resistors and a serial host on the two open-drain pins.
`timescale 1ns/1ns
module strap_far_side (
  // Device pin enables, active low.
  input wire logic clk_oe_n_in,
  input wire logic dat_oe_n_in,
  // Frame control and levels from the bench.
  input wire logic run_in,
  input wire logic dat_level_in,
  input wire logic strap_clk_in,
  input wire logic strap_dat_in,
  // Resolved pin levels.
  output logic clk_line_out,
  output logic dat_line_out
);
  logic host_clk_ff;
  // The host clock toggles every 400 ns only within frames, off the bench clock grid.
  initial begin
    host_clk_ff = 1'h0;
    #17;
    forever begin
      #400;
      host_clk_ff = run_in ? !host_clk_ff : strap_clk_in;
    end
  end
  // A low enable pulls the pin down; otherwise the host or the strap resistor sets it.
  assign clk_line_out = !clk_oe_n_in ? 1'h0 : (run_in ? host_clk_ff : strap_clk_in);
  assign dat_line_out = !dat_oe_n_in ? 1'h0 : (run_in ? dat_level_in : strap_dat_in);
endmodule : strap_far_side

// >>> verification/straps_properties.sv
// Port-level checks for the serial mode and low-power strap block.
`timescale 1ns/1ns
module straps_properties (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Watched inputs.
  input wire logic serial_mode_select_in,
  input wire logic eeprom_clock_drive_low_in,
  input wire logic smbus_data_drive_low_in,
  input wire logic config_present_in,
  input wire logic link_low_power_disable_in,
  // Watched outputs.
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe_n_out,
  input wire logic serial_data_pin_oe_n_out,
  input wire logic eeprom_clock_out,
  input wire logic eeprom_mode_out,
  input wire logic smbus_mode_out,
  input wire logic serial_clock_fall_out,
  input wire logic straps_valid_out,
  input wire logic low_power_accept_out,
  input wire logic low_power_initiate_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Policy, routing, capture timing and edge pulse width.
  cfg_policy_a: assert property (straps_valid_out && config_present_in |=>
    low_power_accept_out == !$past(link_low_power_disable_in)
    && low_power_initiate_out == low_power_accept_out) else $error("config policy wrong");
  strap_hold_a: assert property ($past(straps_valid_out) && !$past(config_present_in)
    && !$past(config_present_in, 2) |-> $stable(low_power_accept_out)
    && $stable(low_power_initiate_out)) else $error("strap policy moved");
  initiate_accept_a: assert property (low_power_initiate_out |-> low_power_accept_out)
    else $error("initiate without accept");
  mode_follow_a: assert property (straps_valid_out && $past(straps_valid_out, 3) |->
    eeprom_mode_out == $past(serial_mode_select_in, 3) && smbus_mode_out != eeprom_mode_out)
    else $error("mode outputs wrong");
  clock_route_a: assert property (eeprom_mode_out && $past(eeprom_mode_out) |->
    serial_clock_pin_oe_n_out == !$past(eeprom_clock_drive_low_in)) else $error("clock route");
  data_route_a: assert property (smbus_mode_out && $past(smbus_mode_out) |->
    serial_data_pin_oe_n_out == !$past(smbus_data_drive_low_in)) else $error("data route");
  idle_release_a: assert property (!straps_valid_out |-> serial_clock_pin_oe_n_out
    && serial_data_pin_oe_n_out && !serial_clock_pin_out) else $error("pin driven early");
  other_line_a: assert property (smbus_mode_out && $past(smbus_mode_out) |->
    eeprom_clock_out) else $error("idle engine line not high");
  capture_time_a: assert property ($rose(straps_valid_out) |-> $past(arst_n_in, 7)
    && !$past(arst_n_in, 8)) else $error("capture at wrong edge");
  fall_pulse_a: assert property (serial_clock_fall_out |=> !serial_clock_fall_out)
    else $error("edge pulse too long");
  // Main scenarios.
  cover property (eeprom_mode_out && !serial_clock_pin_oe_n_out);
  cover property (straps_valid_out && low_power_accept_out && !low_power_initiate_out);
  cover property (straps_valid_out && config_present_in && !low_power_accept_out);
  cover property (serial_clock_fall_out);
endmodule : straps_properties

// >>> verification/serial_mode_and_lowpower_straps_bench.sv
// Self-checking bench for the strap block with a far-side model.
`timescale 1ns/1ns
module serial_mode_and_lowpower_straps_bench;
  logic clk_in, arst_n_in, serial_mode_select_in, serial_clock_pin_in, serial_data_pin_in;
  logic eeprom_clock_drive_low_in, eeprom_data_drive_low_in, smbus_clock_drive_low_in;
  logic smbus_data_drive_low_in, config_present_in, link_low_power_disable_in;
  logic serial_clock_pin_out, serial_clock_pin_oe_n_out, serial_data_pin_out;
  logic serial_data_pin_oe_n_out, eeprom_clock_out, eeprom_data_out, eeprom_mode_out;
  logic smbus_clock_out, smbus_data_out, smbus_mode_out, serial_clock_rise_out;
  logic serial_clock_fall_out, straps_valid_out, low_power_accept_out, low_power_initiate_out;
  logic run, dat_level, strap_clk, strap_dat;
  logic [7:0] rnd, exp_dat;
  wire logic [7:0] pol = {6'h0, low_power_accept_out, low_power_initiate_out};
  wire logic [7:0] dat_seen = {6'h0, eeprom_data_out, smbus_data_out};
  int fails, checks_done, falls, rises;
  serial_mode_and_lowpower_straps u_serial_mode_and_lowpower_straps (.clk_in, .arst_n_in,
    .serial_mode_select_in, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe_n_out, .serial_data_pin_in, .serial_data_pin_out,
    .serial_data_pin_oe_n_out, .eeprom_clock_drive_low_in, .eeprom_data_drive_low_in,
    .eeprom_clock_out, .eeprom_data_out, .eeprom_mode_out, .smbus_clock_drive_low_in,
    .smbus_data_drive_low_in, .smbus_clock_out, .smbus_data_out, .smbus_mode_out,
    .serial_clock_rise_out, .serial_clock_fall_out, .config_present_in,
    .link_low_power_disable_in, .straps_valid_out, .low_power_accept_out,
    .low_power_initiate_out);
  strap_far_side u_strap_far_side (.clk_oe_n_in(serial_clock_pin_oe_n_out),
    .dat_oe_n_in(serial_data_pin_oe_n_out), .run_in(run), .dat_level_in(dat_level),
    .strap_clk_in(strap_clk), .strap_dat_in(strap_dat), .clk_line_out(serial_clock_pin_in),
    .dat_line_out(serial_data_pin_in));
  // Clock generation and edge pulse counting, sampled where the pulses are settled.
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = !clk_in;
  end
  always @(negedge clk_in) begin
    if (serial_clock_fall_out === 1'h1) falls++;
    if (serial_clock_rise_out === 1'h1) rises++;
  end
  // Bench helpers.
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  function automatic logic [7:0] exp_pol(input logic cfg, dis, sda, scl);
    if (cfg) return {6'h0, !dis, !dis};
    if (sda) return 8'h0;
    return scl ? 8'h2 : 8'h3;
  endfunction : exp_pol
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic start(input logic sda, scl, mode);
    arst_n_in = 1'h0;
    {strap_dat, strap_clk, serial_mode_select_in, config_present_in} = {sda, scl, mode, 1'h0};
    {eeprom_clock_drive_low_in, eeprom_data_drive_low_in} = 2'h0;
    {smbus_clock_drive_low_in, smbus_data_drive_low_in} = 2'h0;
    repeat (3) @(negedge clk_in);
    arst_n_in = 1'h1;
    for (int k = 0; k < 20 && straps_valid_out !== 1'h1; k++) @(negedge clk_in);
    if (straps_valid_out !== 1'h1) begin
      fails++;
      $display("unexpected straps_valid_out expected 1 seen %b", straps_valid_out);
      close_out;
    end
  endtask : start
  // Main sequence: one reset per strap pair, then frame, routing and config cases.
  initial begin
    {fails, checks_done, falls, rises, rnd} = {32'h0, 32'h0, 32'h0, 32'h0, 8'h48};
    {run, dat_level, link_low_power_disable_in} = 3'h0;
    for (int i = 0; i < 4; i++) begin
      start(i[1], i[0], i[0]);
      check("policy", exp_pol(1'h0, 1'h0, i[1], i[0]), pol);
      check("mode", {6'h0, !i[0], i[0]}, {6'h0, smbus_mode_out, eeprom_mode_out});
      {falls, rises} = 64'h0;
      run = 1'h1;
      for (int b = 0; b < 32; b++) begin
        // The selected engine sees the data line three edges after it moves.
        exp_dat = i[0] ? {6'h0, dat_level, 1'h1} : {6'h0, 1'h1, dat_level};
        if (b % 4 == 3) check("data", exp_dat, dat_seen);
        rnd = lfsr_next(rnd);
        if (b % 4 == 0) dat_level = rnd[0];
        @(negedge clk_in);
      end
      run = 1'h0;
      repeat (6) @(negedge clk_in);
      check("falls", 8'h4, falls[7:0]);
      check("rises", 8'h4, rises[7:0]);
      check("held", exp_pol(1'h0, 1'h0, i[1], i[0]), pol);
      {eeprom_clock_drive_low_in, smbus_data_drive_low_in} = {2{i[0]}};
      {smbus_clock_drive_low_in, eeprom_data_drive_low_in} = {2{!i[0]}};
      repeat (2) @(negedge clk_in);
      check("oe_n", 8'h1, {6'h0, serial_clock_pin_oe_n_out, serial_data_pin_oe_n_out});
      check("pins", 8'h0, {6'h0, serial_clock_pin_out, serial_data_pin_out});
      repeat (4) @(negedge clk_in);
      check("lines", {6'h0, !i[0], i[0]}, {6'h0, eeprom_clock_out, smbus_clock_out});
      // Swap roles: the selected engine pulls data low, the idle one asks for the clock.
      {eeprom_clock_drive_low_in, smbus_data_drive_low_in} = {2{!i[0]}};
      {smbus_clock_drive_low_in, eeprom_data_drive_low_in} = {2{i[0]}};
      repeat (2) @(negedge clk_in);
      check("oe_n", 8'h2, {6'h0, serial_clock_pin_oe_n_out, serial_data_pin_oe_n_out});
      repeat (4) @(negedge clk_in);
      check("dlines", {6'h0, !i[0], i[0]}, dat_seen);
      {eeprom_clock_drive_low_in, eeprom_data_drive_low_in} = 2'h0;
      {smbus_clock_drive_low_in, smbus_data_drive_low_in} = 2'h0;
      for (int c = 0; c < 3; c++) begin
        rnd = lfsr_next(rnd);
        config_present_in = 1'h1;
        link_low_power_disable_in = rnd[1] ^ c[0];
        repeat (2) @(negedge clk_in);
        check("config", exp_pol(1'h1, rnd[1] ^ c[0], i[1], i[0]), pol);
      end
      config_present_in = 1'h0;
      repeat (2) @(negedge clk_in);
      check("back", exp_pol(1'h0, 1'h0, i[1], i[0]), pol);
      $display("test %0d done", i);
    end
    close_out;
  end
endmodule : serial_mode_and_lowpower_straps_bench
bind serial_mode_and_lowpower_straps straps_properties u_straps_properties (.clk_in,
  .arst_n_in, .serial_mode_select_in, .eeprom_clock_drive_low_in, .smbus_data_drive_low_in,
  .config_present_in, .link_low_power_disable_in, .serial_clock_pin_out,
  .serial_clock_pin_oe_n_out, .serial_data_pin_oe_n_out, .eeprom_clock_out, .eeprom_mode_out,
  .smbus_mode_out, .serial_clock_fall_out, .straps_valid_out, .low_power_accept_out,
  .low_power_initiate_out);
